// ---- psa_pkg.sv ----
package psa_pkg;
  localparam int DATA_W = 16;
  localparam int PROG_W = 24;
  localparam int PWORD_W = 24;
  localparam int PAGE_W = 8;
  localparam int PAGE_MSB = 7;
  localparam int VIS_LOW_W = 15;
  localparam int EA_MSB = 15;
  localparam int PC_W = 23;
  localparam logic [PC_W-1:0] PC_STEP = 23'h000002;
  localparam logic [PC_W-1:0] PC_RESET = 23'h000000;
  localparam int CFG_IMPL_LO = 0;
  localparam logic [PROG_W-1:0] CFG_IMPL_BASE = 24'hff0000;
  localparam logic [PROG_W-1:0] CFG_IMPL_LAST = 24'hff0003;
  localparam logic [PAGE_W-1:0] PAGE_RESET = 8'h00;

  typedef enum logic [2:0] {
    PSA_OP_NONE = 3'h0,
    PSA_OP_RDL  = 3'h1,
    PSA_OP_RDH  = 3'h2,
    PSA_OP_WRL  = 3'h3,
    PSA_OP_WRH  = 3'h4
  } psa_op_t;

  typedef struct packed {
    psa_op_t            op;
    logic               byte_mode;
    logic [DATA_W-1:0]  ea;
    logic [DATA_W-1:0]  wdata;
  } psa_tbl_req_t;

  typedef struct packed {
    logic               rd;
    logic [DATA_W-1:0]  ea;
  } psa_data_req_t;

  typedef struct packed {
    logic               rd;
    logic               wr;
    logic               cfg;
    logic [PROG_W-1:0]  addr;
    logic [PWORD_W-1:0] wdata;
    logic [2:0]         lane;
  } psa_mem_req_t;

  typedef enum logic [1:0] {
    PSA_ST_IDLE = 2'b00,
    PSA_ST_WAIT = 2'b01,
    PSA_ST_DONE = 2'b11
  } psa_state_t;
endpackage

// ---- psa_access_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
module psa_access_unit (
  input  wire logic                          clk_sys_i,
  input  wire logic                          rst_i,
  input  wire logic [psa_pkg::PAGE_W-1:0]    table_page_i,
  input  wire logic [psa_pkg::PAGE_W-1:0]    window_page_i,
  input  wire logic                          program_window_enable_i,
  input  wire logic                          pc_advance_i,
  input  wire logic                          pc_load_i,
  input  wire logic [psa_pkg::PC_W-1:0]      pc_load_value_i,
  input  wire psa_pkg::psa_tbl_req_t         tbl_req_i,
  input  wire psa_pkg::psa_data_req_t        data_req_i,
  input  wire logic [psa_pkg::PWORD_W-1:0]   mem_rdata_i,
  output psa_pkg::psa_mem_req_t              mem_req_o,
  output logic [psa_pkg::PROG_W-1:0]         fetch_addr_o,
  output logic [psa_pkg::DATA_W-1:0]         rdata_o,
  output logic                               rvalid_o,
  output logic                               window_hit_o,
  output logic                               stall_o,
  output logic                               tbl_refused_o
);
  import psa_pkg::*;

  psa_state_t                st;
  psa_state_t                next_st;
  logic [PC_W-1:0]           pc;
  psa_op_t                   op_q;
  logic                      byte_q;
  logic                      sel_q;
  logic                      win_q;
  logic                      tbl_go;
  logic                      win_go;
  logic                      cfg_sel;
  logic                      cfg_ok;
  logic                      wr_op;
  logic [PROG_W-1:0]         tbl_addr;
  logic [PROG_W-1:0]         win_addr;
  logic [DATA_W-1:0]         next_rdata;

  assign wr_op    = (tbl_req_i.op == PSA_OP_WRL) || (tbl_req_i.op == PSA_OP_WRH);
  assign tbl_addr = {table_page_i, tbl_req_i.ea};
  assign cfg_sel  = table_page_i[PAGE_MSB];
  assign cfg_ok   = (tbl_addr >= CFG_IMPL_BASE) && (tbl_addr <= CFG_IMPL_LAST);
  assign tbl_go   = (st == PSA_ST_IDLE) && (tbl_req_i.op != PSA_OP_NONE)
                    && !(cfg_sel && (wr_op || !cfg_ok));
  assign win_go   = (st == PSA_ST_IDLE) && data_req_i.rd
                    && data_req_i.ea[EA_MSB] && program_window_enable_i
                    && (tbl_req_i.op == PSA_OP_NONE);
  assign win_addr = {1'b0, window_page_i, data_req_i.ea[VIS_LOW_W-1:1], 1'b0};

  always_comb begin
    next_st = st;
    case (st)
      PSA_ST_IDLE: if (tbl_go || win_go) next_st = PSA_ST_WAIT;
      PSA_ST_WAIT: next_st = PSA_ST_DONE;
      PSA_ST_DONE: next_st = PSA_ST_IDLE;
      default:     next_st = PSA_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) st <= PSA_ST_IDLE;
    else st <= next_st;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) pc <= PC_RESET;
    else if (pc_load_i) pc <= {pc_load_value_i[PC_W-1:1], 1'b0};
    else if (pc_advance_i) pc <= pc + PC_STEP;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) fetch_addr_o <= '0;
    else fetch_addr_o <= {1'b0, pc[PC_W-1:1], 1'b0};
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      op_q   <= PSA_OP_NONE;
      byte_q <= 1'b0;
      sel_q  <= 1'b0;
      win_q  <= 1'b0;
    end else if (st == PSA_ST_IDLE) begin
      op_q   <= tbl_go ? tbl_req_i.op : PSA_OP_NONE;
      byte_q <= tbl_req_i.byte_mode;
      sel_q  <= tbl_req_i.ea[0];
      win_q  <= win_go && !tbl_go;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mem_req_o <= '0;
    end else if (tbl_go) begin
      mem_req_o.rd    <= !wr_op;
      mem_req_o.wr    <= wr_op;
      mem_req_o.cfg   <= cfg_sel;
      mem_req_o.addr  <= tbl_addr;
      mem_req_o.wdata <= (tbl_req_i.op == PSA_OP_WRH)
                         ? {tbl_req_i.wdata[7:0], 16'h0000}
                         : {8'h00, tbl_req_i.wdata};
      if (tbl_req_i.op == PSA_OP_WRH)
        mem_req_o.lane <= tbl_req_i.byte_mode ? {!tbl_req_i.ea[0], 2'b00} : 3'h4;
      else if (tbl_req_i.byte_mode)
        mem_req_o.lane <= {1'b0, tbl_req_i.ea[0], !tbl_req_i.ea[0]};
      else
        mem_req_o.lane <= 3'h3;
    end else if (win_go) begin
      mem_req_o.rd    <= 1'b1;
      mem_req_o.wr    <= 1'b0;
      mem_req_o.cfg   <= 1'b0;
      mem_req_o.addr  <= win_addr;
      mem_req_o.wdata <= '0;
      mem_req_o.lane  <= 3'h3;
    end else begin
      mem_req_o <= '0;
    end
  end

  always_comb begin
    next_rdata = '0;
    if (win_q) begin
      next_rdata = mem_rdata_i[15:0];
    end else begin
      case (op_q)
        PSA_OP_RDL: begin
          if (!byte_q) next_rdata = mem_rdata_i[15:0];
          else next_rdata = {8'h00, sel_q ? mem_rdata_i[15:8] : mem_rdata_i[7:0]};
        end
        PSA_OP_RDH: begin
          if (!byte_q) next_rdata = {8'h00, mem_rdata_i[23:16]};
          else next_rdata = {8'h00, sel_q ? 8'h00 : mem_rdata_i[23:16]};
        end
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata_o  <= '0;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= (st == PSA_ST_DONE)
                  && (win_q || op_q == PSA_OP_RDL || op_q == PSA_OP_RDH);
      rdata_o  <= (st == PSA_ST_DONE) ? next_rdata : '0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      window_hit_o  <= 1'b0;
      stall_o       <= 1'b0;
      tbl_refused_o <= 1'b0;
    end else begin
      window_hit_o  <= win_go && !tbl_go;
      stall_o       <= (next_st != PSA_ST_IDLE);
      tbl_refused_o <= (st == PSA_ST_IDLE) && (tbl_req_i.op != PSA_OP_NONE) && !tbl_go;
    end
  end

  a_cfg_no_write: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    mem_req_o.cfg |-> !mem_req_o.wr)
    else $error("write issued to configuration space");
  a_win_user_only: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    window_hit_o |-> !mem_req_o.addr[PROG_W-1] && !mem_req_o.addr[0] && !mem_req_o.wr)
    else $error("window access left user space");
  a_win_page_bit: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    window_hit_o |-> mem_req_o.addr[EA_MSB] == $past(window_page_i[0]))
    else $error("window bit 15 wrong");
  a_win_no_cfg: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    window_hit_o |-> !mem_req_o.cfg)
    else $error("window access marked configuration");
  a_win_latency: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    window_hit_o |-> ##2 rvalid_o)
    else $error("window read latency wrong");
  a_win_enable: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    window_hit_o |-> $past(program_window_enable_i))
    else $error("window used while disabled");
  a_win_suspend: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    window_hit_o |-> $past(tbl_req_i.op) == PSA_OP_NONE)
    else $error("window during table op");
  a_win_low_bits: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    window_hit_o |-> mem_req_o.addr[VIS_LOW_W-1:1] == $past(data_req_i.ea[VIS_LOW_W-1:1]))
    else $error("window low address bits wrong");
  a_win_read_only: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    window_hit_o |-> mem_req_o.rd && !mem_req_o.wr)
    else $error("window access not a read");
  a_win_rdata: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    rvalid_o && $past(win_q) |-> rdata_o == $past(mem_rdata_i[15:0]))
    else $error("window read data wrong");
  a_tbl_page: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (mem_req_o.rd || mem_req_o.wr) && !window_hit_o
    |-> mem_req_o.addr[PROG_W-1 -: PAGE_W] == $past(table_page_i))
    else $error("table page wrong");
  a_tbl_ea_kept: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (mem_req_o.rd || mem_req_o.wr) && !window_hit_o
    |-> mem_req_o.addr[DATA_W-1:0] == $past(tbl_req_i.ea))
    else $error("table effective address altered");
  a_cfg_flag: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (mem_req_o.rd || mem_req_o.wr) && !window_hit_o
    |-> mem_req_o.cfg == $past(table_page_i[PAGE_MSB]))
    else $error("configuration select wrong");
  a_byte_select: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (mem_req_o.rd || mem_req_o.wr) && !window_hit_o |-> sel_q == $past(tbl_req_i.ea[0]))
    else $error("byte select not taken from address bit 0");
  a_refuse_no_req: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    tbl_refused_o |-> !mem_req_o.rd && !mem_req_o.wr)
    else $error("refused table operation reached memory");
  a_refuse_cfg: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    tbl_refused_o |-> $past(table_page_i[PAGE_MSB]))
    else $error("user table operation refused");
  a_fetch_align: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    !fetch_addr_o[0] && !fetch_addr_o[PROG_W-1])
    else $error("fetch address not aligned");
  a_pc_load: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    pc_load_i |=> pc == {$past(pc_load_value_i[PC_W-1:1]), 1'b0})
    else $error("pc load wrong");
  a_pc_step: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    pc_advance_i && !pc_load_i |=> pc == $past(pc) + PC_STEP)
    else $error("pc step wrong");
  a_low_no_upper: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    mem_req_o.wr && $past(tbl_req_i.op) == PSA_OP_WRL |-> !mem_req_o.lane[2])
    else $error("low write touched upper byte");
  a_lane_high: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    mem_req_o.wr && $past(tbl_req_i.op) == PSA_OP_WRH && !$past(tbl_req_i.byte_mode)
    |-> mem_req_o.lane == 3'h4)
    else $error("high word write lane wrong");
  a_write_quiet: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    mem_req_o.wr |-> ##2 !rvalid_o)
    else $error("write produced read data");
  a_rdl_word: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    rvalid_o && $past(op_q) == PSA_OP_RDL && !$past(byte_q) && !$past(win_q)
    |-> rdata_o == $past(mem_rdata_i[15:0]))
    else $error("low word read data wrong");
  a_rdl_byte: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    rvalid_o && $past(op_q) == PSA_OP_RDL && $past(byte_q) && !$past(win_q)
    |-> rdata_o == {8'h00, $past(sel_q) ? $past(mem_rdata_i[15:8]) : $past(mem_rdata_i[7:0])})
    else $error("low byte read data wrong");
  a_high_zero: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    rvalid_o |-> rdata_o[15:8] == 8'h00 || $past(win_q)
    || $past(op_q) == PSA_OP_RDL && !$past(byte_q))
    else $error("upper data byte not zero");
  a_rdh_word: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    rvalid_o && $past(op_q) == PSA_OP_RDH && !$past(byte_q)
    |-> rdata_o == {8'h00, $past(mem_rdata_i[23:16])})
    else $error("high word read data wrong");
  a_phantom_zero: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    rvalid_o && $past(op_q) == PSA_OP_RDH && $past(byte_q) && $past(sel_q) |-> rdata_o == '0)
    else $error("phantom byte not zero");
  a_stall_busy: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    mem_req_o.rd |-> stall_o)
    else $error("stall missing during access");
  a_rvalid_pulse: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    rvalid_o |=> !rvalid_o)
    else $error("read valid longer than one cycle");

  c_win_read:  cover property (@(posedge clk_sys_i) window_hit_o ##2 rvalid_o);
  c_tbl_high:  cover property (@(posedge clk_sys_i) mem_req_o.rd && mem_req_o.addr[PROG_W-1]);
  c_refused:   cover property (@(posedge clk_sys_i) tbl_refused_o);
  c_tbl_write: cover property (@(posedge clk_sys_i) mem_req_o.wr);
  c_byte_read: cover property (@(posedge clk_sys_i) rvalid_o && byte_q && sel_q);
endmodule
`default_nettype wire

// ---- psa_flash_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module psa_flash_model
  import psa_pkg::*;
(
  input  wire logic                   clk_sys_i,
  input  wire logic                   rst_i,
  input  wire psa_pkg::psa_mem_req_t  mem_req_i,
  output logic [psa_pkg::PWORD_W-1:0] rdata_o
);
  // Data is valid only in the cycle after a read; otherwise the bus toggles.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata_o <= 24'h5a5a5a;
    end else if (mem_req_i.rd) begin
      rdata_o <= {mem_req_i.addr[7:0] ^ 8'h3c, mem_req_i.addr[15:0] ^ 16'ha5c3};
    end else begin
      rdata_o <= ~rdata_o;
    end
  end
endmodule
`default_nettype wire

// ---- program_space_access_unit_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module program_space_access_unit_tb_top;
  import psa_pkg::*;
  logic           clk_sys_i = 1'b0;
  logic           rst_i = 1'b1;
  logic [7:0]     pg = 8'h00, wp = 8'h00;
  logic           wen = 1'b0, adv = 1'b0, ld = 1'b0;
  logic [22:0]    ldv = '0, pcx;
  psa_tbl_req_t   tq = '0;
  psa_data_req_t  dq = '0;
  logic [23:0]    mrd;
  psa_mem_req_t   mq, m;
  logic [23:0]    fa;
  logic [15:0]    rd, ea, wd;
  logic           rv, hit, stl, rfs, rf, h, bm;
  psa_op_t        op;
  int             err_total = 0, check_count = 0, seed = 40783, n, i;
  always #20 clk_sys_i = ~clk_sys_i;
  psa_access_unit dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .table_page_i(pg),
    .window_page_i(wp), .program_window_enable_i(wen), .pc_advance_i(adv), .pc_load_i(ld),
    .pc_load_value_i(ldv), .tbl_req_i(tq), .data_req_i(dq), .mem_rdata_i(mrd), .mem_req_o(mq),
    .fetch_addr_o(fa), .rdata_o(rd), .rvalid_o(rv), .window_hit_o(hit), .stall_o(stl),
    .tbl_refused_o(rfs));
  psa_flash_model fm (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .mem_req_i(mq), .rdata_o(mrd));
  function automatic logic [23:0] pw(logic [23:0] a);
    return {a[7:0] ^ 8'h3c, a[15:0] ^ 16'ha5c3};
  endfunction
  function automatic logic [15:0] xr(psa_op_t o, logic b, logic [15:0] e, logic [23:0] p);
    if (o == PSA_OP_RDL) return b ? {8'h00, e[0] ? p[15:8] : p[7:0]} : p[15:0];
    return (b && e[0]) ? 16'h0000 : {8'h00, p[23:16]};
  endfunction
  task automatic complete_run();
    if (err_total == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [23:0] seen, logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic run();
    n = 0;
    do begin
      @(posedge clk_sys_i);
      #1 n++;
    end while (!(mq.rd || mq.wr || rfs) && n < 6);
    if (n == 6) begin
      err_total++;
      complete_run();
    end
    m = mq;
    rf = rfs;
    h = hit;
    chk("stall busy", 24'(stl), 24'(mq.rd || mq.wr));
    @(posedge clk_sys_i);
    tq <= '0;
    dq <= '0;
    #1 n = 1;
    while (m.rd && !rv && n < 6) begin
      @(posedge clk_sys_i);
      #1 n++;
    end
    if (m.rd && !rv) begin
      err_total++;
      complete_run();
    end
    if (m.rd) chk("stall idle", 24'(stl), 24'h0);
  endtask
  initial begin
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    #1 chk("reset outs", {mq.rd, mq.wr, rv, hit, stl, rfs, rd}, 24'h0);
    for (i = 0; i < 16; i++) begin
      @(posedge clk_sys_i);
      op = psa_op_t'(3'(1 + i % 4));
      bm = i[2];
      ea = 16'($random(seed));
      wd = 16'($random(seed));
      pg <= {1'b0, 7'($random(seed))};
      tq <= '{op, bm, ea, wd};
      run();
      chk("table addr", m.addr, {pg, ea});
      chk("table cfg", 24'(m.cfg), 24'h0);
      if (op <= PSA_OP_RDH) begin
        chk("table rdata", 24'(rd), 24'(xr(op, bm, ea, pw({pg, ea}))));
      end else if (!bm) begin
        chk("write data", op == PSA_OP_WRL ? 24'(m.wdata[15:0]) : 24'(m.wdata[23:16]),
            op == PSA_OP_WRL ? 24'(wd) : 24'(wd[7:0]));
      end
      if (op >= PSA_OP_WRL) begin
        chk("write lane", {m.wr, m.lane}, {1'b1, op == PSA_OP_WRH
            ? (bm ? {!ea[0], 2'b00} : 3'h4) : (bm ? {1'b0, ea[0], !ea[0]} : 3'h3)});
      end
    end
    for (i = 0; i < 3; i++) begin
      @(posedge clk_sys_i);
      pg <= 8'hff;
      tq <= '{i == 2 ? PSA_OP_WRL : PSA_OP_RDL, 1'b0, i == 1 ? 16'h0040 : 16'h0002, 16'h1234};
      run();
      chk("cfg refuse", 24'(rf), 24'(i != 0));
      chk("cfg flag", 24'(m.cfg & m.rd), 24'(i == 0));
    end
    wen <= 1'b1;
    pg <= 8'h00;
    for (i = 0; i < 5; i++) begin
      @(posedge clk_sys_i);
      ea = 16'h8000 | 16'($random(seed));
      wp <= 8'($random(seed));
      dq <= '{1'b1, ea};
      if (i == 4) tq <= '{PSA_OP_RDL, 1'b0, 16'h0010, 16'h0000};
      run();
      if (i == 4) begin
        chk("table first", {23'(m.addr), h}, {pg, 16'h0010} << 1);
      end else begin
        chk("win addr", m.addr, {1'b0, wp, ea[14:1], 1'b0});
        chk("win read", {m.wr, rd, h}, {1'b0, 16'(pw({1'b0, wp, ea[14:1], 1'b0})), 1'b1});
        chk("win delay", 24'(n), 24'h2);
      end
    end
    @(posedge clk_sys_i);
    wen <= 1'b0;
    dq <= '{1'b1, 16'hc000};
    h = 1'b0;
    repeat (5) begin
      @(posedge clk_sys_i);
      #1 h = h | hit | mq.rd;
    end
    chk("win disabled", 24'(h), 24'h0);
    dq <= '0;
    ldv <= 23'($random(seed));
    ld <= 1'b1;
    @(posedge clk_sys_i);
    ld <= 1'b0;
    adv <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    adv <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1 pcx = {ldv[22:1], 1'b0} + 23'd6;
    chk("fetch addr", fa, {1'b0, pcx[22:1], 1'b0});
    complete_run();
  end
endmodule
`default_nettype wire
